// >>> rtl/msd_decoder.sv
`timescale 1ns/1ns
// Memory space decoder: data/program steering, page register, on-chip RAM

// Behaviour
// R01: Data addresses in RAM bounds go internal
// R02: Program fetch outside on-chip memory goes external
// R03: On-chip accesses answer next cycle, no waits; here a data read into RAM stalls when an overlay fetch takes port A
// R04: Extended program address on 23 lines
// R05: 128 pages of 64K, page from register
// R06: Page register at 001Eh, reset to zero
// R07: Boot select low at reset: start FF80h
// R08: Large: 128K ROM, optional 16K data
// R09: Small: 64K ROM in program space only
// R10: ROM image regions: codec, boot, tables, vectors
// R11: Software leaves FF00h-FF7Fh unused in ROM
// R12: RAM built of 8K blocks, five large
// R13: Each block: two reads or read+write
// R14: Large RAM at 0080h-9FFFh, overlay to program
// R15: Small RAM at 0080h-3FFFh, overlay governed
// R16: Overlay puts RAM in every page's low half
// R17: Extended address is page then 16 bits
module msd_decoder
  import msd_pkg::*;
#(
  parameter bit LARGE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode inputs
  input wire logic boot_mode_select,
  input wire logic ram_overlay_enable,
  input wire logic rom_data_enable,
  // Program fetch from the program address generator
  input wire logic pf_req,
  input wire logic [15:0] pf_addr,
  // Data read port
  input wire logic dr_req,
  input wire logic [15:0] dr_addr,
  // Data read/write port
  input wire logic dw_req,
  input wire logic dw_we,
  input wire logic [15:0] dw_addr,
  input wire logic [15:0] dw_wdata,
  // Results of internal accesses
  output logic pf_valid,
  output msd_src_type pf_src,
  output logic [15:0] pf_rdata,
  output logic [2:0] pf_rom_region,
  output logic dr_valid,
  output logic [15:0] dr_rdata,
  output logic dw_valid,
  output logic [15:0] dw_rdata,
  output logic dr_stall,
  output logic dr_rom_hit,
  output logic dw_rom_hit,
  // External accesses
  output msd_ext_prog_type ext_prog,
  output msd_ext_data_type ext_data_r,
  output msd_ext_data_type ext_data_w,
  // Page and boot state
  output logic [15:0] program_page_select,
  output logic boot_from_rom,
  output logic [15:0] reset_fetch_addr
);
  localparam int NBLK = LARGE ? MSD_BLOCKS_LARGE : MSD_BLOCKS_SMALL;
  localparam logic [15:0] RAM_TOP = LARGE ? MSD_RAM_TOP_LARGE : MSD_RAM_TOP_SMALL;
  localparam logic [15:0] RAM_OVERLAY_ENABLE_TOP = LARGE ? MSD_RAM_OVERLAY_ENABLE_TOP_LARGE : MSD_RAM_OVERLAY_ENABLE_TOP_SMALL;
  localparam logic [6:0] ROM_PAGES = LARGE ? MSD_ROM_PAGES_LARGE : MSD_ROM_PAGES_SMALL;

  initial begin
    if (NBLK > 8) begin
      $error("msd_decoder: too many RAM blocks");
    end
  end

  // True when an address lies in the data RAM window
  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= MSD_RAM_BASE) && (a <= RAM_TOP);
  endfunction : in_ram

  // Which ROM image region a program address falls in
  function automatic logic [2:0] rom_region(input logic [15:0] a);
    if (a >= MSD_RESET_VECTOR) begin
      rom_region = 3'h5;
    end else if (a >= MSD_TEST_BASE && a <= MSD_TEST_TOP) begin
      rom_region = 3'h4;
    end else if (a >= MSD_TABLE_BASE) begin
      rom_region = 3'h3;
    end else if (a >= MSD_BOOT_BASE && a <= MSD_BOOT_TOP) begin
      rom_region = 3'h2;
    end else if (a >= MSD_CODEC_BASE && a <= MSD_CODEC_TOP) begin
      rom_region = 3'h1;
    end else begin
      rom_region = 3'h0;
    end
  endfunction : rom_region

  // Boot select pin: three-stage synchroniser, caught after reset release
  logic boot_s1;
  logic boot_s2;
  logic boot_s3;
  logic boot_caught;
  logic boot_low;
  logic [1:0] boot_fill;

  // Count edges until all three stages hold the pin, not their reset value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_fill <= 2'h0;
    end else if (boot_fill != 2'h3) begin
      boot_fill <= boot_fill + 2'h1;
    end
  end

  // Synchroniser stages
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_s1 <= 1'b1;
      boot_s2 <= 1'b1;
      boot_s3 <= 1'b1;
    end else begin
      boot_s1 <= boot_mode_select;
      boot_s2 <= boot_s1;
      boot_s3 <= boot_s2;
    end
  end

  // Latch the mode once the last two stages agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_caught <= 1'b0;
      boot_low <= 1'b0;
    end else if (!boot_caught && (boot_fill == 2'h3) && (boot_s2 == boot_s3)) begin
      boot_caught <= 1'b1;
      boot_low <= ~boot_s3; // R07
    end
  end

  // Page register
  logic [MSD_PAGE_BITS-1:0] page;
  wire page_wr = dw_req && dw_we && (dw_addr == MSD_PAGE_REG_ADDR);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page <= MSD_PAGE_RESET[MSD_PAGE_BITS-1:0]; // R06
    end else if (page_wr) begin
      page <= dw_wdata[MSD_PAGE_BITS-1:0]; // R05
    end
  end
  wire [15:0] page_word = {{(16-MSD_PAGE_BITS){1'b0}}, page};

  // Program space decode
  wire pf_low = pf_addr <= RAM_OVERLAY_ENABLE_TOP;
  wire pf_ram = ram_overlay_enable && pf_low && in_ram(pf_addr); // R14 R15 R16
  wire pf_rsv = ram_overlay_enable && pf_low && !pf_ram; // R16
  wire pf_rom = boot_low && (pf_addr >= MSD_ROM_BASE) && (page < ROM_PAGES); // R08 R09
  wire pf_int = pf_ram || pf_rsv || pf_rom;
  wire [22:0] pf_ext_addr = {page, pf_addr}; // R04 R17

  // Data space decode
  wire dr_mmr = dr_addr <= MSD_MMR_TOP;
  wire dw_mmr = dw_addr <= MSD_MMR_TOP;
  wire dr_ram = in_ram(dr_addr); // R01
  wire dw_ram = in_ram(dw_addr); // R01
  wire drom_ok = LARGE && rom_data_enable; // R08
  wire dr_drom = drom_ok && (dr_addr >= MSD_DROM_BASE);
  wire dw_drom = drom_ok && (dw_addr >= MSD_DROM_BASE) && !dw_we;
  wire dr_int = dr_mmr || dr_ram || dr_drom;
  wire dw_int = dw_mmr || dw_ram || (drom_ok && (dw_addr >= MSD_DROM_BASE));

  // Port A is shared: a program fetch into RAM takes it first
  wire a_use_pf = pf_req && pf_ram;
  wire [15:0] a_addr = a_use_pf ? pf_addr : dr_addr;
  wire dr_blocked = a_use_pf && dr_req && dr_ram;

  // RAM blocks: 8K words each, selected by the top address bits
  logic [15:0] a_data [0:NBLK-1];
  logic [15:0] b_data [0:NBLK-1];
  for (genvar g = 0; g < NBLK; g++) begin : g_blk
    wire b_sel = dw_req && dw_we && dw_ram && (dw_addr[15:MSD_BLOCK_AW] == 3'(g));
    msd_ram_block #(.AW(MSD_BLOCK_AW)) u_blk ( // R12 R13
      .clk_sys(clk_sys),
      .a_addr(a_addr[MSD_BLOCK_AW-1:0]),
      .a_rdata(a_data[g]),
      .b_we(b_sel),
      .b_addr(dw_addr[MSD_BLOCK_AW-1:0]),
      .b_wdata(dw_wdata),
      .b_rdata(b_data[g])
    );
  end

  // Read data selection
  wire [15:0] a_word = a_data[a_addr[15:MSD_BLOCK_AW]];
  wire [15:0] b_word = b_data[dw_addr[15:MSD_BLOCK_AW]];
  wire [15:0] dr_word = (dr_addr == MSD_PAGE_REG_ADDR) ? page_word :
                        (dr_ram ? a_word : 16'h0000);
  wire [15:0] dw_word = (dw_addr == MSD_PAGE_REG_ADDR) ? page_word :
                        (dw_ram ? b_word : 16'h0000);
  wire msd_src_type next_pf_src = pf_ram ? MSD_SRC_RAM :
                                  pf_rsv ? MSD_SRC_RSV :
                                  pf_rom ? MSD_SRC_ROM : MSD_SRC_EXT;

  // Internal results, answered one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pf_valid <= 1'b0;
      pf_src <= MSD_SRC_EXT;
      pf_rdata <= 16'h0000;
      pf_rom_region <= 3'h0;
      dr_valid <= 1'b0;
      dr_rdata <= 16'h0000;
      dw_valid <= 1'b0;
      dw_rdata <= 16'h0000;
      dr_stall <= 1'b0;
      dr_rom_hit <= 1'b0;
      dw_rom_hit <= 1'b0;
    end else begin
      pf_valid <= pf_req && pf_int; // R03
      pf_src <= next_pf_src;
      pf_rdata <= pf_ram ? a_word : 16'h0000;
      pf_rom_region <= pf_rom ? rom_region(pf_addr) : 3'h0; // R10
      dr_valid <= dr_req && dr_int && !dr_blocked; // R03
      dr_rdata <= dr_word;
      dw_valid <= dw_req && dw_int; // R03
      dw_rdata <= dw_word;
      dr_stall <= dr_blocked;
      dr_rom_hit <= dr_req && dr_drom;
      dw_rom_hit <= dw_req && dw_drom;
    end
  end

  // External requests, launched one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_prog <= '0;
      ext_data_r <= '0;
      ext_data_w <= '0;
    end else begin
      ext_prog <= '{req: pf_req && !pf_int, addr: pf_ext_addr}; // R02
      ext_data_r <= '{req: dr_req && !dr_int, we: 1'b0, addr: dr_addr,
                      wdata: 16'h0000}; // R01
      ext_data_w <= '{req: dw_req && !dw_int, we: dw_we, addr: dw_addr,
                      wdata: dw_wdata}; // R01
    end
  end

  // Page and boot status outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_page_select <= MSD_PAGE_RESET;
      boot_from_rom <= 1'b0;
      reset_fetch_addr <= MSD_RESET_VECTOR;
    end else begin
      program_page_select <= page_word;
      boot_from_rom <= boot_low; // R07
      reset_fetch_addr <= MSD_RESET_VECTOR;
    end
  end
endmodule : msd_decoder

// >>> rtl/msd_pkg.sv
// Package for the memory space decoder: map constants and carrier types
package msd_pkg;
  // Memory-mapped page register
  localparam logic [15:0] MSD_PAGE_REG_ADDR = 16'h001E;
  localparam logic [15:0] MSD_PAGE_RESET = 16'h0000;
  localparam int MSD_PAGE_BITS = 7;
  // Data space layout
  localparam logic [15:0] MSD_MMR_TOP = 16'h007F;
  localparam logic [15:0] MSD_RAM_BASE = 16'h0080;
  localparam logic [15:0] MSD_RAM_TOP_LARGE = 16'h9FFF;
  localparam logic [15:0] MSD_RAM_TOP_SMALL = 16'h3FFF;
  localparam logic [15:0] MSD_DROM_BASE = 16'hC000;
  // Program space layout
  localparam logic [15:0] MSD_RAM_OVERLAY_ENABLE_TOP_LARGE = 16'h7FFF;
  localparam logic [15:0] MSD_RAM_OVERLAY_ENABLE_TOP_SMALL = 16'h3FFF;
  localparam logic [15:0] MSD_ROM_BASE = 16'h8000;
  localparam logic [6:0] MSD_ROM_PAGES_LARGE = 7'h04;
  localparam logic [6:0] MSD_ROM_PAGES_SMALL = 7'h02;
  localparam logic [15:0] MSD_RESET_VECTOR = 16'hFF80;
  localparam logic [15:0] MSD_CODEC_BASE = 16'hC000;
  localparam logic [15:0] MSD_CODEC_TOP = 16'hD4FF;
  localparam logic [15:0] MSD_BOOT_BASE = 16'hF800;
  localparam logic [15:0] MSD_BOOT_TOP = 16'hFBFF;
  localparam logic [15:0] MSD_TABLE_BASE = 16'hFC00;
  localparam logic [15:0] MSD_TEST_BASE = 16'hFF00;
  localparam logic [15:0] MSD_TEST_TOP = 16'hFF7F;
  // RAM block geometry: 8K words per block
  localparam int MSD_BLOCK_AW = 13;
  localparam int MSD_BLOCKS_LARGE = 5;
  localparam int MSD_BLOCKS_SMALL = 2;

  // Program fetch towards the outside
  typedef struct packed {
    logic req;
    logic [22:0] addr;
  } msd_ext_prog_type;

  // Data access towards the outside
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } msd_ext_data_type;

  // Where a program fetch was served
  typedef enum logic [1:0] {
    MSD_SRC_EXT = 2'b00,
    MSD_SRC_RAM = 2'b01,
    MSD_SRC_ROM = 2'b11,
    MSD_SRC_RSV = 2'b10
  } msd_src_type;
endpackage : msd_pkg

// >>> rtl/msd_ram_block.sv
`timescale 1ns/1ns
// One 8K-word dual-access RAM block: read port A, read/write port B
module msd_ram_block #(
  parameter int AW = 13
) (
  // Clock
  input wire logic clk_sys,
  // Port A, read only
  input wire logic [AW-1:0] a_addr,
  output logic [15:0] a_rdata,
  // Port B, read or write
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [15:0] b_wdata,
  output logic [15:0] b_rdata
);
  logic [15:0] mem [0:(1<<AW)-1];

  // Two reads, or one read and one write, every cycle
  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  // Write port
  always_ff @(posedge clk_sys) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end
endmodule : msd_ram_block

// >>> verification/msd_decoder_asserts.sv
`timescale 1ns/1ns
// Checker for the memory space decoder's port behaviour
module msd_decoder_chk
  import msd_pkg::*;
#(
  parameter bit LARGE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched inputs
  input wire logic ram_overlay_enable,
  input wire logic pf_req,
  input wire logic [15:0] pf_addr,
  input wire logic dr_req,
  input wire logic [15:0] dr_addr,
  input wire logic dw_req,
  input wire logic dw_we,
  input wire logic [15:0] dw_addr,
  input wire logic [15:0] dw_wdata,
  // Watched outputs
  input wire logic pf_valid,
  input wire logic dw_valid,
  input wire msd_ext_prog_type ext_prog,
  input wire msd_ext_data_type ext_data_r,
  input wire msd_ext_data_type ext_data_w,
  input wire logic [15:0] program_page_select
);
  // Address classes per variant
  wire [15:0] ram_top = LARGE ? MSD_RAM_TOP_LARGE : MSD_RAM_TOP_SMALL;
  wire [15:0] ovl_top = LARGE ? MSD_RAM_OVERLAY_ENABLE_TOP_LARGE : MSD_RAM_OVERLAY_ENABLE_TOP_SMALL;
  wire dr_in = dr_addr >= MSD_RAM_BASE && dr_addr <= ram_top;
  wire dw_in = dw_addr >= MSD_RAM_BASE && dw_addr <= ram_top;
  wire pf_in = ram_overlay_enable && pf_addr >= MSD_RAM_BASE && pf_addr <= ovl_top;
  wire dr_out = dr_addr > ram_top && dr_addr < MSD_DROM_BASE;
  wire page_wr = dw_req && dw_we && dw_addr == MSD_PAGE_REG_ADDR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Fetch steering and addressing
  pf_ram_hit_a: assert property (pf_req && pf_in |=> pf_valid && !ext_prog.req)
    else $error("overlay fetch went out");
  pf_ext_a: assert property (pf_req && !ram_overlay_enable && !pf_addr[15] |=> ext_prog.req)
    else $error("low fetch not external");
  ext_addr_a: assert property (pf_req ##1 ext_prog.req |-> ext_prog.addr[15:0] == $past(pf_addr))
    else $error("external fetch address wrong");
  ext_page_a: assert property (ext_prog.req |-> ext_prog.addr[22:16] == program_page_select[6:0])
    else $error("external fetch page wrong");
  // Page register
  page_top_a: assert property (program_page_select[15:7] == 9'h000)
    else $error("page upper bits set");
  page_rst_a: assert property ($rose(rst_n) |-> program_page_select == MSD_PAGE_RESET)
    else $error("page not cleared by reset");
  page_wr_a: assert property (page_wr |-> ##2 program_page_select[6:0] == $past(dw_wdata[6:0], 2))
    else $error("page write lost");
  // Data steering
  dr_int_a: assert property (dr_req && dr_in |=> !ext_data_r.req)
    else $error("RAM read went out");
  dr_ext_a: assert property (dr_req && dr_out |=> ext_data_r.req && ext_data_r.addr == $past(dr_addr))
    else $error("outside read not external");
  dw_int_a: assert property (dw_req && dw_in |=> dw_valid && !ext_data_w.req)
    else $error("RAM write not done at once");
endmodule : msd_decoder_chk
bind msd_decoder msd_decoder_chk #(.LARGE(LARGE)) i_msd_decoder_chk (.clk_sys, .rst_n,
  .ram_overlay_enable, .pf_req, .pf_addr, .dr_req, .dr_addr, .dw_req, .dw_we, .dw_addr,
  .dw_wdata, .pf_valid, .dw_valid, .ext_prog, .ext_data_r, .ext_data_w, .program_page_select);

// >>> verification/msd_ext_mem.sv
`timescale 1ns/1ns
// External memory model: keeps the last fetch address and the last write that the decoder sends off chip
module msd_ext_mem
  import msd_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requests from the decoder
  input wire msd_ext_prog_type ext_prog,
  input wire msd_ext_data_type ext_data_w,
  // Last transfers seen
  output logic [22:0] last_prog_addr,
  output logic [31:0] last_wr
);
  // Take each request at once, so no wait is added from here
  always_ff @(posedge clk_sys) begin
    if (ext_prog.req) begin
      last_prog_addr <= ext_prog.addr;
    end
    if (ext_data_w.req && ext_data_w.we) begin
      last_wr <= {ext_data_w.addr, ext_data_w.wdata};
    end
  end
endmodule : msd_ext_mem

// >>> verification/tb.sv
`timescale 1ns/1ns
// Self-checking bench for the memory space decoder
module tb;
  import msd_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, boot_mode_select = 1'b0, ram_overlay_enable = 1'b0;
  logic rom_data_enable = 1'b0, pf_req = 1'b0, dr_req = 1'b0, dw_req = 1'b0, dw_we = 1'b0;
  logic [15:0] pf_addr = 16'h0, dr_addr = 16'h0, dw_addr = 16'h0, dw_wdata = 16'h0;
  logic pf_valid, dr_valid, dw_valid, dr_stall, dr_rom_hit, dw_rom_hit, boot_from_rom;
  logic [15:0] pf_rdata, dr_rdata, dw_rdata, program_page_select, reset_fetch_addr;
  logic [2:0] pf_rom_region;
  msd_src_type pf_src;
  msd_ext_prog_type ext_prog;
  msd_ext_data_type ext_data_r, ext_data_w;
  logic [22:0] last_prog_addr;
  logic [31:0] last_wr;
  logic [15:0] a, v, pg;
  logic [15:0] rom_a [6] = '{16'hC000, 16'hD4FF, 16'hF800, 16'hFC00, 16'hFF00, 16'hFF80};
  int error_cnt = 0, checked = 0, seed = 32'h992d, i;
  msd_decoder i_msd_decoder (.clk_sys, .rst_n, .boot_mode_select, .ram_overlay_enable,
    .rom_data_enable, .pf_req, .pf_addr, .dr_req, .dr_addr, .dw_req, .dw_we, .dw_addr,
    .dw_wdata, .pf_valid, .pf_src, .pf_rdata, .pf_rom_region, .dr_valid, .dr_rdata, .dw_valid,
    .dw_rdata, .dr_stall, .dr_rom_hit, .dw_rom_hit, .ext_prog, .ext_data_r, .ext_data_w,
    .program_page_select, .boot_from_rom, .reset_fetch_addr);
  msd_ext_mem i_msd_ext_mem (.clk_sys, .ext_prog, .ext_data_w, .last_prog_addr, .last_wr);
  // Clock
  always #50 clk_sys = ~clk_sys;
  // ROM region expected for a fetch address
  function automatic logic [2:0] region(input logic [15:0] x);
    if (x >= MSD_RESET_VECTOR) return 3'h5;
    if (x >= MSD_TEST_BASE) return 3'h4;
    if (x >= MSD_TABLE_BASE) return 3'h3;
    if (x >= MSD_BOOT_BASE) return 3'h2;
    if (x >= MSD_CODEC_BASE && x <= MSD_CODEC_TOP) return 3'h1;
    return 3'h0;
  endfunction : region
  // Compare one result
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One request on the chosen ports; results sampled after the answer edge
  task acc(input logic p, input logic r, input logic w, input logic [15:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    pf_req <= p;
    dr_req <= r;
    dw_req <= w;
    dw_we <= w;
    pf_addr <= ad;
    dr_addr <= ad;
    dw_addr <= ad;
    dw_wdata <= d;
    @(posedge clk_sys);
    pf_req <= 1'b0;
    dr_req <= 1'b0;
    dw_req <= 1'b0;
    #1;
  endtask : acc
  // Verdict and end of run
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk({boot_from_rom, reset_fetch_addr}, {1'b1, MSD_RESET_VECTOR});
    acc(0, 1, 0, MSD_PAGE_REG_ADDR, 16'h0);
    chk(dr_rdata, MSD_PAGE_RESET);
    for (i = 0; i < 10; i++) begin
      a = i == 0 ? MSD_RAM_BASE : i == 1 ? MSD_RAM_TOP_LARGE : 16'h80 + $unsigned($random(seed)) % 40832;
      v = $random(seed);
      acc(0, 0, 1, a, v);
      chk({dw_valid, ext_data_w.req}, 2'b10);
      acc(0, 1, 1, a, ~v);
      chk({dr_valid, dr_rdata, dw_rdata}, {1'b1, v, v});
      acc(0, 1, 0, a, 16'h0);
      chk({dr_valid, ext_data_r.req, dr_rdata}, {2'b10, ~v});
    end
    a = 16'hA000 + ($random(seed) & 16'h1FFF);
    acc(0, 0, 1, a, v);
    chk({dw_valid, ext_data_w.req}, 2'b01);
    @(posedge clk_sys);
    #1;
    chk({dw_valid, last_wr}, {1'b0, a, v});
    pg = $random(seed);
    acc(0, 0, 1, MSD_PAGE_REG_ADDR, pg);
    acc(0, 1, 0, MSD_PAGE_REG_ADDR, 16'h0);
    chk({dr_rdata, program_page_select}, {2{9'h0, pg[6:0]}});
    a = $random(seed) & 16'h7FFF;
    acc(1, 0, 0, a, 16'h0);
    chk({pf_valid, ext_prog.req}, 2'b01);
    @(posedge clk_sys);
    #1;
    chk({pf_valid, last_prog_addr}, {1'b0, pg[6:0], a});
    a = 16'h80 + ($random(seed) & 16'h3FFF);
    acc(0, 0, 1, a, v);
    ram_overlay_enable <= 1'b1;
    acc(1, 0, 0, a, 16'h0);
    chk({pf_valid, pf_src, ext_prog.req, pf_rdata}, {1'b1, MSD_SRC_RAM, 1'b0, v});
    acc(1, 1, 0, a, 16'h0);
    chk({dr_stall, dr_valid, pf_valid}, 3'b101);
    acc(1, 0, 0, MSD_MMR_TOP, 16'h0);
    chk({pf_valid, pf_src, ext_prog.req}, {1'b1, MSD_SRC_RSV, 1'b0});
    ram_overlay_enable <= 1'b0;
    acc(1, 0, 0, a, 16'h0);
    chk({pf_valid, ext_prog.req}, 2'b01);
    acc(0, 0, 1, MSD_PAGE_REG_ADDR, 16'h0003);
    for (i = 0; i < 9; i++) begin
      a = i < 6 ? rom_a[i] : 16'h8000 | $random(seed);
      acc(1, 0, 0, a, 16'h0);
      chk({pf_valid, pf_src, pf_rom_region}, {1'b1, MSD_SRC_ROM, region(a)});
    end
    acc(0, 0, 1, MSD_PAGE_REG_ADDR, 16'h0004);
    acc(1, 0, 0, 16'h8000, 16'h0);
    chk({pf_valid, ext_prog.req}, 2'b01);
    rom_data_enable <= 1'b1;
    acc(0, 1, 0, MSD_DROM_BASE, 16'h0);
    chk({dr_rom_hit, ext_data_r.req}, 2'b10);
    acc(0, 0, 1, MSD_DROM_BASE, v);
    chk({dw_valid, dw_rom_hit, ext_data_w.req}, 3'b100);
    rom_data_enable <= 1'b0;
    acc(0, 1, 0, MSD_DROM_BASE, 16'h0);
    chk({dr_rom_hit, ext_data_r.req}, 2'b01);
    print_verdict();
  end
endmodule : tb
